//--- dbc_consts.vh
// Constants of the device bus controller: register map, fields, reset values, timing.
`ifndef DBC_CONSTS_VH
`define DBC_CONSTS_VH

// ****************************************************************
// Register word indices (byte offset divided by four)
// ****************************************************************
`define DBC_IDX_PARAM0   6'h00
`define DBC_IDX_WIN0     6'h08
`define DBC_IDX_REQADDR  6'h10
`define DBC_IDX_REQCTRL  6'h11
`define DBC_IDX_WDATA    6'h12
`define DBC_IDX_RDATA    6'h13
`define DBC_IDX_STATUS   6'h14

// ****************************************************************
// Bank parameter fields
// ****************************************************************
`define DBC_F_TURN   2:0
`define DBC_F_FIRST  6:3
`define DBC_F_NEXT   10:7
`define DBC_F_A2W    13:11
`define DBC_F_LOW    16:14
`define DBC_F_GAP    19:17
`define DBC_F_WIDTH  21:20
`define DBC_F_LEAD   29:28
`define DBC_PARAM_RST 32'h002FFFFF

// ****************************************************************
// Window fields, base and size in 1 MB units
// ****************************************************************
`define DBC_F_BASE   11:0
`define DBC_F_SIZE   24:16
`define DBC_WIN0_RST 32'h01FF0000
`define DBC_WIN1_RST 32'h01FF0200
`define DBC_WIN2_RST 32'h01FF0400
`define DBC_WIN3_RST 32'h01FF0600
`define DBC_WIN4_RST 32'h00000FFF
`define DBC_BOOT_BANK 3'h4

// ****************************************************************
// Minimum timing settings and limits
// ****************************************************************
`define DBC_MIN_TURN  3'h1
`define DBC_MIN_FIRST 4'h3
`define DBC_MIN_NEXT  4'h1
`define DBC_MIN_A2W   3'h3
`define DBC_MIN_LOW   3'h1
`define DBC_FLOAT_CYC 3'h5
`define DBC_ADDR_CYC  5'h01
`define DBC_MAX_PEND  3'h4
`define DBC_BUF_WORDS 6'h20

`endif

//--- dbc_device_bus.v
// Device bus controller: APB register slave, request queue, buffers and bus sequencer.
// Functional notes
// - Five banks, windows in 1MB steps, 512MB max.
// - Per-bank width 8/16/32 and timing values.
// - Boot bank defaults to boot address, strap width.
// - Address phase drives address, bank select, direction.
// - Access strobe active for whole device access.
// - Write data with active-low lane strobes; no read enables.
// - Outputs float in reset plus five cycles.
// - 128-byte buffers, four reads, four writes outstanding.
// - Address driven two cycles, then latch strobe drops.
// - Write data popped cycle after latch drop.
// - Posted writes wait for earlier transactions.
// - Read data returned once whole burst is buffered.
// - Bus released after read, at least one cycle.
// - First read sample after latch rise, min three.
// - Next burst sample spacing, minimum one.
// - Latch drop to write strobe delay, min three.
// - Write pulse width, min one, data stable.
// - Write gap cycles; data changes on last gap.
// - Zero gap only with write pulse width one.
// - Burst address leads read sample by lead field.
// - Wait for ready when delay counts expire.
`include "dbc_consts.vh"

module dbc_device_bus (
  input  wire        clk,
  input  wire        rstn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [31:0] adIn,
  output reg  [31:0] adOut,
  output reg         adOe,
  output reg         ctlOe,
  output reg         addrLatch,
  output reg  [4:0]  bankSelN,
  output reg         dirIndicator,
  output reg         accessStrobeN,
  output reg  [3:0]  writeLaneN,
  output reg  [2:0]  burstAddrLow,
  input  wire        readyN,
  input  wire [1:0]  bootWidth
);

  localparam [7:0] S_IDLE  = 8'h01;
  localparam [7:0] S_ADDR  = 8'h02;
  localparam [7:0] S_LATCH = 8'h04;
  localparam [7:0] S_RWAIT = 8'h08;
  localparam [7:0] S_WSET  = 8'h10;
  localparam [7:0] S_WLOW  = 8'h20;
  localparam [7:0] S_WHIGH = 8'h40;
  localparam [7:0] S_TURN  = 8'h80;

  reg [31:0] paramQ [0:4];
  reg [31:0] winQ   [0:4];
  reg [31:0] wbuf   [0:31];
  reg [31:0] rbuf   [0:31];
  reg [31:0] cqAddr [0:7];
  reg [10:0] cqCtl  [0:7];
  reg [31:0] reqAddrQ;
  reg [2:0]  cqWp, cqRp;
  reg [3:0]  cqCount;
  reg [2:0]  rdPend, wrPend;
  reg [4:0]  wwp, wrp, rwp, rrp;
  reg [5:0]  wbCount, rbHeld, rbAvail;
  reg        errFlag, strapTaken;
  reg [2:0]  floatCnt;
  reg [7:0]  stateQ;
  reg [4:0]  cntQ;
  reg [2:0]  beatQ, beatsQ, bankQ;
  reg [3:0]  beQ;
  reg        dirQ;
  integer    j;

  // ****************************************************************
  // Bank decode of the request address
  // ****************************************************************
  reg        hit;
  reg [2:0]  hitBank;
  reg [11:0] offMb;
  integer    i;
  always @*
  begin
    hit = 1'b0;
    hitBank = 3'h0;
    offMb = 12'h000;
    for (i = 4; i >= 0; i = i - 1)
    begin
      offMb = reqAddrQ[31:20] - winQ[i][`DBC_F_BASE];
      if (reqAddrQ[31:20] >= winQ[i][`DBC_F_BASE] &&
          offMb <= {3'h0, winQ[i][`DBC_F_SIZE]})
      begin
        hit = 1'b1;
        hitBank = i[2:0];
      end
    end
  end

  // ****************************************************************
  // Effective timing of the active bank, clamped to legal minimums
  // ****************************************************************
  wire [31:0] curPar = paramQ[bankQ];
  wire [2:0] turnE  = (curPar[`DBC_F_TURN] < `DBC_MIN_TURN) ? `DBC_MIN_TURN
                      : curPar[`DBC_F_TURN];
  wire [3:0] firstE = (curPar[`DBC_F_FIRST] < `DBC_MIN_FIRST) ? `DBC_MIN_FIRST
                      : curPar[`DBC_F_FIRST];
  wire [3:0] nextE  = (curPar[`DBC_F_NEXT] < `DBC_MIN_NEXT) ? `DBC_MIN_NEXT
                      : curPar[`DBC_F_NEXT];
  wire [2:0] a2wE   = (curPar[`DBC_F_A2W] < `DBC_MIN_A2W) ? `DBC_MIN_A2W
                      : curPar[`DBC_F_A2W];
  wire [2:0] lowE   = (curPar[`DBC_F_LOW] < `DBC_MIN_LOW) ? `DBC_MIN_LOW
                      : curPar[`DBC_F_LOW];
  // A zero gap is only honoured with a one-cycle pulse; otherwise it acts as one.
  wire [2:0] gapE   = (curPar[`DBC_F_GAP] == 3'h0 && lowE != 3'h1) ? 3'h1
                      : curPar[`DBC_F_GAP];
  wire [1:0] leadE  = curPar[`DBC_F_LEAD];
  wire [1:0] widthE = curPar[`DBC_F_WIDTH];

  wire [4:0] rdTarget = (beatQ == 3'h0) ? {1'b0, firstE} : {1'b0, nextE};
  wire       rdSample = (stateQ == S_RWAIT) && (cntQ >= rdTarget) && !readyN;
  wire       rdLast   = (beatQ == beatsQ);
  wire       leadNow  = ({3'h0, leadE} + 5'h01 >= {1'b0, nextE});
  wire [4:0] leadCnt  = {1'b0, nextE} - {3'h0, leadE} - 5'h01;
  wire [31:0] rdWord  = (widthE == 2'h0) ? {24'h000000, adIn[7:0]} :
                        (widthE == 2'h1) ? {16'h0000, adIn[15:0]} : adIn;
  wire       wrEnd    = (stateQ == S_WLOW) && (cntQ >= {2'h0, lowE}) && !readyN;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  wire [5:0] idx    = paddr[7:2];
  wire       mapped = (paddr[1:0] == 2'h0) &&
                      (idx < 6'h05 || (idx >= `DBC_IDX_WIN0 && idx < 6'h0D) ||
                       (idx >= `DBC_IDX_REQADDR && idx <= `DBC_IDX_STATUS));
  wire       take   = psel && penable && pready;
  wire       wrAcc  = take && pwrite && mapped;
  wire       rdPop  = take && !pwrite && idx == `DBC_IDX_RDATA && rbAvail != 6'h00;
  wire       pushWd = wrAcc && idx == `DBC_IDX_WDATA && wbCount != `DBC_BUF_WORDS;
  wire       reqCmd = wrAcc && idx == `DBC_IDX_REQCTRL;
  wire       cmdOk  = hit && (pwdata[0] ? rdPend < `DBC_MAX_PEND
                      : wrPend < `DBC_MAX_PEND);
  wire       pushCmd = reqCmd && cmdOk;

  wire [10:0] headCtl = cqCtl[cqRp];
  wire [5:0]  headBeats = {3'h0, headCtl[3:1]} + 6'h01;
  wire        canStart = ctlOe && cqCount != 4'h0 && (headCtl[0] ?
                         (`DBC_BUF_WORDS - rbHeld) >= headBeats : wbCount >= headBeats);
  wire        popWb = (stateQ == S_LATCH && !dirQ) ||
                      (wrEnd && !rdLast && gapE <= 3'h1) ||
                      (stateQ == S_WHIGH && gapE >= 3'h2 &&
                       cntQ == {2'h0, gapE} - 5'h01);
  wire        startGo = (stateQ == S_IDLE) && canStart;
  wire        rdDone  = rdSample && rdLast;
  wire        wrDone  = wrEnd && rdLast;

  reg [31:0] rdMux;
  always @*
  begin
    rdMux = 32'h00000000;
    if (idx < 6'h05)
      rdMux = paramQ[idx[2:0]];
    else if (idx >= `DBC_IDX_WIN0 && idx < 6'h0D)
      rdMux = winQ[idx[2:0]];
    else if (idx == `DBC_IDX_REQADDR)
      rdMux = reqAddrQ;
    else if (idx == `DBC_IDX_RDATA)
      rdMux = rbuf[rrp];
    else if (idx == `DBC_IDX_STATUS)
      rdMux = {11'h000, ctlOe, wbCount, rbAvail, wrPend, rdPend, errFlag,
               (stateQ != S_IDLE)};
  end

  // ****************************************************************
  // Buffer storage, no reset needed
  // ****************************************************************
  always @(posedge clk)
  begin
    if (pushWd)
      wbuf[wwp] <= pwdata;
    if (rdSample)
      rbuf[rwp] <= rdWord;
  end

  // ****************************************************************
  // Registers, queue and bus sequencer
  // ****************************************************************
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (j = 0; j < 5; j = j + 1)
        paramQ[j] <= `DBC_PARAM_RST;
      for (j = 0; j < 8; j = j + 1)
      begin
        cqAddr[j] <= 32'h00000000;
        cqCtl[j] <= 11'h000;
      end
      winQ[0] <= `DBC_WIN0_RST;
      winQ[1] <= `DBC_WIN1_RST;
      winQ[2] <= `DBC_WIN2_RST;
      winQ[3] <= `DBC_WIN3_RST;
      winQ[4] <= `DBC_WIN4_RST;
      reqAddrQ <= 32'h00000000;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      cqWp <= 3'h0;
      cqRp <= 3'h0;
      cqCount <= 4'h0;
      rdPend <= 3'h0;
      wrPend <= 3'h0;
      wwp <= 5'h00;
      wrp <= 5'h00;
      rwp <= 5'h00;
      rrp <= 5'h00;
      wbCount <= 6'h00;
      rbHeld <= 6'h00;
      rbAvail <= 6'h00;
      errFlag <= 1'b0;
      strapTaken <= 1'b0;
      floatCnt <= 3'h0;
      stateQ <= S_IDLE;
      cntQ <= 5'h00;
      beatQ <= 3'h0;
      beatsQ <= 3'h0;
      bankQ <= 3'h0;
      beQ <= 4'h0;
      dirQ <= 1'b0;
      adOut <= 32'h00000000;
      adOe <= 1'b0;
      ctlOe <= 1'b0;
      addrLatch <= 1'b0;
      bankSelN <= 5'h1F;
      dirIndicator <= 1'b0;
      accessStrobeN <= 1'b1;
      writeLaneN <= 4'hF;
      burstAddrLow <= 3'h0;
    end
    else
    begin
      // Pins stay floating for a fixed count after release; the strobe relies on a pull.
      if (floatCnt != `DBC_FLOAT_CYC)
        floatCnt <= floatCnt + 3'h1;
      if (floatCnt == `DBC_FLOAT_CYC - 3'h1)
        ctlOe <= 1'b1;
      if (!strapTaken)
      begin
        strapTaken <= 1'b1;
        paramQ[`DBC_BOOT_BANK][`DBC_F_WIDTH] <= bootWidth;
      end

      pready <= psel && penable && !pready;
      if (psel && penable && !pready)
      begin
        prdata <= pwrite ? 32'h00000000 : rdMux;
        pslverr <= !mapped;
      end
      if (wrAcc && idx < 6'h05)
        paramQ[idx[2:0]] <= pwdata;
      if (wrAcc && idx >= `DBC_IDX_WIN0 && idx < 6'h0D)
        winQ[idx[2:0]] <= pwdata;
      if (wrAcc && idx == `DBC_IDX_REQADDR)
        reqAddrQ <= pwdata;
      // A new error beats a clear in the same cycle.
      if ((reqCmd && !cmdOk) || (wrAcc && idx == `DBC_IDX_WDATA && !pushWd))
        errFlag <= 1'b1;
      else if (wrAcc && idx == `DBC_IDX_STATUS && pwdata[1])
        errFlag <= 1'b0;

      if (pushCmd)
      begin
        cqAddr[cqWp] <= reqAddrQ;
        cqCtl[cqWp] <= {hitBank, pwdata[7:4], pwdata[3:1], pwdata[0]};
        cqWp <= cqWp + 3'h1;
      end
      cqCount <= cqCount + {3'h0, pushCmd} - {3'h0, startGo};
      rdPend <= rdPend + {2'h0, pushCmd && pwdata[0]} - {2'h0, rdDone};
      wrPend <= wrPend + {2'h0, pushCmd && !pwdata[0]} - {2'h0, wrDone};
      if (pushWd)
        wwp <= wwp + 5'h01;
      wbCount <= wbCount + {5'h00, pushWd} - {5'h00, popWb};
      if (popWb)
      begin
        adOut <= wbuf[wrp];
        wrp <= wrp + 5'h01;
      end
      if (rdSample)
        rwp <= rwp + 5'h01;
      if (rdPop)
        rrp <= rrp + 5'h01;
      rbHeld <= rbHeld + {5'h00, rdSample} - {5'h00, rdPop};
      rbAvail <= rbAvail + (rdDone ? {3'h0, beatsQ} + 6'h01 : 6'h00)
                 - {5'h00, rdPop};

      case (stateQ)
        S_IDLE:
        begin
          if (startGo)
          begin
            // Queue order makes a posted write wait for every earlier access.
            cqRp <= cqRp + 3'h1;
            dirQ <= headCtl[0];
            beatsQ <= headCtl[3:1];
            beQ <= headCtl[7:4];
            bankQ <= headCtl[10:8];
            beatQ <= 3'h0;
            cntQ <= 5'h00;
            adOut <= cqAddr[cqRp];
            adOe <= 1'b1;
            addrLatch <= 1'b1;
            bankSelN <= ~(5'h01 << headCtl[10:8]);
            dirIndicator <= headCtl[0];
            burstAddrLow <= cqAddr[cqRp][4:2];
            accessStrobeN <= 1'b0;
            stateQ <= S_ADDR;
          end
        end
        S_ADDR:
        begin
          cntQ <= cntQ + 5'h01;
          if (cntQ == `DBC_ADDR_CYC)
          begin
            addrLatch <= 1'b0;
            stateQ <= S_LATCH;
          end
        end
        S_LATCH:
        begin
          if (dirQ)
          begin
            adOe <= 1'b0;
            cntQ <= cntQ + 5'h01;
            stateQ <= S_RWAIT;
          end
          else
          begin
            cntQ <= 5'h01;
            stateQ <= S_WSET;
          end
        end
        S_RWAIT:
        begin
          if (rdSample)
          begin
            beatQ <= beatQ + 3'h1;
            cntQ <= 5'h01;
            if (rdLast)
            begin
              accessStrobeN <= 1'b1;
              bankSelN <= 5'h1F;
              stateQ <= S_TURN;
            end
            else if (leadNow)
              burstAddrLow <= burstAddrLow + 3'h1;
          end
          else
          begin
            if (cntQ < rdTarget)
              cntQ <= cntQ + 5'h01;
            if (beatQ != 3'h0 && !leadNow && cntQ == leadCnt)
              burstAddrLow <= burstAddrLow + 3'h1;
          end
        end
        S_WSET:
        begin
          cntQ <= cntQ + 5'h01;
          if (cntQ == {2'h0, a2wE} - 5'h01)
          begin
            writeLaneN <= ~beQ;
            cntQ <= 5'h01;
            stateQ <= S_WLOW;
          end
        end
        S_WLOW:
        begin
          if (cntQ < {2'h0, lowE})
            cntQ <= cntQ + 5'h01;
          if (wrEnd)
          begin
            cntQ <= 5'h01;
            beatQ <= beatQ + 3'h1;
            if (rdLast)
            begin
              writeLaneN <= 4'hF;
              adOe <= 1'b0;
              accessStrobeN <= 1'b1;
              bankSelN <= 5'h1F;
              stateQ <= S_IDLE;
            end
            else
            begin
              if (gapE <= 3'h1)
                burstAddrLow <= burstAddrLow + 3'h1;
              if (gapE != 3'h0)
              begin
                writeLaneN <= 4'hF;
                stateQ <= S_WHIGH;
              end
            end
          end
        end
        S_WHIGH:
        begin
          cntQ <= cntQ + 5'h01;
          if (gapE >= 3'h2 && cntQ == {2'h0, gapE} - 5'h01)
            burstAddrLow <= burstAddrLow + 3'h1;
          if (cntQ == {2'h0, gapE})
          begin
            writeLaneN <= ~beQ;
            cntQ <= 5'h01;
            stateQ <= S_WLOW;
          end
        end
        S_TURN:
        begin
          cntQ <= cntQ + 5'h01;
          if (cntQ >= {2'h0, turnE})
            stateQ <= S_IDLE;
        end
        default:
        begin
          stateQ <= S_IDLE;
        end
      endcase
    end
  end

endmodule

//--- dbc_device_bus_sva.sv
// Port timing checker for the device bus controller.
module dbc_device_bus_sva (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [31:0] adOut,
  input wire logic        adOe,
  input wire logic        ctlOe,
  input wire logic        addrLatch,
  input wire logic [4:0]  bankSelN,
  input wire logic        dirIndicator,
  input wire logic        accessStrobeN,
  input wire logic [3:0]  writeLaneN,
  input wire logic [2:0]  burstAddrLow,
  input wire logic        readyN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] relCnt_q;

  // Counts edges since reset release; saturates so it never wraps back into the float window.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      relCnt_q <= 3'h0;
    else if (relCnt_q != 3'h7)
      relCnt_q <= relCnt_q + 3'h1;
  end

  default clocking dcb @(posedge clk); endclocking
  default disable iff (!rstn);

  // ****************************************************************
  // Device bus properties
  // ****************************************************************
  AST_FLOAT: assert property (relCnt_q < 3'h5 |-> !ctlOe && !adOe)
    else $error("device bus driven too early after reset");
  AST_ADDR2: assert property ($rose(addrLatch) |=> addrLatch && $stable(adOut) ##1 !addrLatch)
    else $error("address phase not two cycles");
  AST_SEL: assert property (addrLatch |-> adOe && ctlOe && $onehot(~bankSelN) && !accessStrobeN)
    else $error("address phase outputs wrong");
  AST_STROBE: assert property (writeLaneN != 4'hF |-> !accessStrobeN && bankSelN != 5'h1F)
    else $error("write pulse outside access strobe");
  AST_IDLE: assert property (accessStrobeN |-> bankSelN == 5'h1F)
    else $error("bank select outside access");
  AST_NOLANES: assert property (dirIndicator |-> writeLaneN == 4'hF)
    else $error("lane strobe during read");
  AST_A2W: assert property ($fell(addrLatch) && !dirIndicator |-> (writeLaneN == 4'hF) [*3])
    else $error("write strobe before minimum delay");
  AST_WDRIVE: assert property ($fell(addrLatch) && !dirIndicator |-> adOe ##1 adOe)
    else $error("write data not driven after latch");
  AST_RELEASE: assert property ($rose(accessStrobeN) && dirIndicator |-> !adOe ##1 !adOe)
    else $error("bus driven at end of read");
  AST_READY: assert property (writeLaneN != 4'hF && readyN |=> writeLaneN != 4'hF)
    else $error("write pulse ended without ready");
endmodule

bind dbc_device_bus dbc_device_bus_sva u_sva (
  .clk(clk), .rstn(rstn), .adOut(adOut), .adOe(adOe), .ctlOe(ctlOe), .addrLatch(addrLatch),
  .bankSelN(bankSelN), .dirIndicator(dirIndicator), .accessStrobeN(accessStrobeN),
  .writeLaneN(writeLaneN), .burstAddrLow(burstAddrLow), .readyN(readyN)
);

//--- dbc_dev_model.sv
// Behavioural model of the address latch and an attached memory device.
module dbc_dev_model (
  input  wire logic        clk,
  input  wire logic [31:0] adOut,
  input  wire logic        adOe,
  input  wire logic        ctlOe,
  input  wire logic        addrLatch,
  input  wire logic [4:0]  bankSelN,
  input  wire logic        dirIndicator,
  input  wire logic        accessStrobeN,
  input  wire logic [3:0]  writeLaneN,
  input  wire logic [2:0]  burstAddrLow,
  input  wire logic        slowMode,
  output logic      [31:0] adIn,
  output logic             readyN,
  output logic      [4:0]  latchedSel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:7];
  logic [31:0] junk_q = 32'h5A5AC3C3;
  logic        latDir_q = 1'b1;
  logic [1:0]  rdyCnt_q = 2'h0;
  // The pull-up holds the strobe inactive while the controller floats it.
  wire         strobeN = ctlOe ? accessStrobeN : 1'b1;

  initial
  begin
    latchedSel = 5'h1F;
    for (int i = 0; i < 8; i++)
      mem[i] = 32'hA5A50000 | i;
  end

  always @(posedge clk)
  begin
    junk_q <= ~junk_q;
    rdyCnt_q <= strobeN ? 2'h0 : rdyCnt_q + 2'h1;
    if (ctlOe && addrLatch)
    begin
      latchedSel <= bankSelN;
      latDir_q <= dirIndicator;
    end
    for (int b = 0; b < 4; b++)
      if (!strobeN && !latDir_q && !writeLaneN[b])
        mem[burstAddrLow][8*b +: 8] <= adOut[8*b +: 8];
  end

  // A slow device answers ready one cycle in four.
  assign readyN = slowMode && !strobeN && rdyCnt_q != 2'h3;
  // Outside its read slot the device bus carries a changing pattern, never the last value.
  assign adIn = (!strobeN && latDir_q && !adOe) ? mem[burstAddrLow] : junk_q;
endmodule

//--- dbc_device_bus_tb.sv
// Self-checking testbench of the device bus controller.
module dbc_device_bus_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rstn, psel, penable, pwrite, slowMode, pready, pslverr, err;
  logic        adOe, ctlOe, addrLatch, dirIndicator, accessStrobeN, readyN;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, adIn, adOut, rd;
  logic [4:0]  bankSelN, latchedSel;
  logic [3:0]  writeLaneN;
  logic [2:0]  burstAddrLow;
  logic [1:0]  bootWidth;
  logic [31:0] expMem [0:7];
  int          fail_count = 0;
  int          cmp_count = 0;
  int          cycCnt = 0;

  always #4 clk = ~clk;

  dbc_device_bus u_dut (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .adIn(adIn),
    .adOut(adOut), .adOe(adOe), .ctlOe(ctlOe), .addrLatch(addrLatch), .bankSelN(bankSelN),
    .dirIndicator(dirIndicator), .accessStrobeN(accessStrobeN), .writeLaneN(writeLaneN),
    .burstAddrLow(burstAddrLow), .readyN(readyN), .bootWidth(bootWidth)
  );

  dbc_dev_model u_model (
    .clk(clk), .adOut(adOut), .adOe(adOe), .ctlOe(ctlOe), .addrLatch(addrLatch),
    .bankSelN(bankSelN), .dirIndicator(dirIndicator), .accessStrobeN(accessStrobeN),
    .writeLaneN(writeLaneN), .burstAddrLow(burstAddrLow), .slowMode(slowMode),
    .adIn(adIn), .readyN(readyN), .latchedSel(latchedSel)
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task give_verdict;
    if (fail_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reads wait in queue order behind any posted write, so read-back proves the ordering.
  task doRead(input logic [31:0] a, input logic [2:0] nm, input logic [4:0] sel);
    apb(1'b1, 8'h40, a, rd, err);
    apb(1'b1, 8'h44, {28'h0, nm, 1'b1}, rd, err);
    do apb(1'b0, 8'h50, 32'h0, rd, err); while (rd[13:8] !== {3'h0, nm} + 6'h01);
    chk({27'h0, latchedSel}, {27'h0, sel});
    for (int i = 0; i <= nm; i++)
    begin
      apb(1'b0, 8'h4C, 32'h0, rd, err);
      chk(rd, expMem[a[4:2] + i]);
    end
  endtask

  task doWrite(input logic [31:0] a, input logic [2:0] nm, input logic [3:0] be,
               input logic [31:0] base);
    apb(1'b1, 8'h40, a, rd, err);
    for (int i = 0; i <= nm; i++)
    begin
      apb(1'b1, 8'h48, base + i, rd, err);
      for (int b = 0; b < 4; b++)
        if (be[b])
          expMem[a[4:2] + i][8*b +: 8] = base[8*b +: 8] + (b == 0 ? i : 0);
    end
    apb(1'b1, 8'h44, {24'h0, be, nm, 1'b0}, rd, err);
  endtask

  // ****************************************************************
  // Sequence and timeout
  // ****************************************************************
  always @(posedge clk)
  begin
    cycCnt <= cycCnt + 1;
    if (cycCnt == 40000)
    begin
      fail_count++;
      give_verdict;
    end
  end

  initial
  begin
    {rstn, psel, penable, pwrite, slowMode, paddr, pwdata} = '0;
    bootWidth = 2'h1;
    for (int i = 0; i < 8; i++)
      expMem[i] = 32'hA5A50000 | i;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0, rd, err);
    chk(rd, 32'h002FFFFF);
    apb(1'b0, 8'h30, 32'h0, rd, err);
    chk(rd, 32'h00000FFF);
    apb(1'b0, 8'h10, 32'h0, rd, err);
    chk(rd, 32'h001FFFFF);
    apb(1'b0, 8'h60, 32'h0, rd, err);
    chk({31'h0, err}, 32'h00000001);
    // The strap makes the boot bank 16 bits wide, so only the low halfword comes back.
    expMem[1] = 32'h00000001;
    doRead(32'hFFF00004, 3'h0, 5'h0F);
    doRead(32'h20000000, 3'h0, 5'h1D);
    for (int c = 0; c < 2; c++)
    begin
      slowMode <= c[0];
      apb(1'b1, 8'h00, c ? 32'h1024A1B2 : 32'h00205899, rd, err);
      doRead(32'h00000008, 3'h1, 5'h1E);
      doWrite(32'h00000010, 3'h1, 4'hF, 32'hC0DE0010 + c * 16);
      doWrite(32'h00000000, 3'h0, 4'h3, 32'h3344BEE0 + c);
      doRead(32'h00000010, 3'h1, 5'h1E);
      doRead(32'h00000000, 3'h0, 5'h1E);
    end
    give_verdict;
  end
endmodule
